//--- rtl/timer_pair_defs.svh
/*
 * constants for the lower timer control block: register offset, fields, timing.
 * assumes a 20 MHz clk and a 32-bit APB slave with word-aligned registers.
 */
`ifndef TIMER_PAIR_DEFS_SVH
`define TIMER_PAIR_DEFS_SVH

// =====================================================================
// register map
`define CTRL_OFFSET 12'h000
`define STAT_OFFSET 12'h004
`define CTRL_RESET 16'h0000
`define CTRL_WMASK 16'ha07a

// =====================================================================
// control fields
`define RUN_BIT 15
`define IDLE_BIT 13
`define GATE_BIT 6
`define PS_HI 5
`define PS_LO 4
`define PAIR_BIT 3
`define SRC_BIT 1

// =====================================================================
// prescale terminal counts (divide minus one)
`define PS_DIV1 8'h00
`define PS_DIV8 8'h07
`define PS_DIV64 8'h3f
`define PS_DIV256 8'hff

// =====================================================================
// timing
`define CLK_PERIOD_NS 50
`define INSTR_DIV 2
`define INSTR_CYCLES (`INSTR_DIV)

`endif

//--- rtl/timer_pair_pkg.sv
/*
 * types for the lower timer control block.
 * assumes timer_pair_defs.svh for all numbers.
 */
package timer_pair_pkg;
    typedef logic [1:0] prescale_sel_t;
    typedef logic [15:0] ctrl_word_t;
endpackage

//--- rtl/tick_if.sv
/*
 * carrier between control logic and the prescaler.
 * assumes one clock domain.
 */
`timescale 1ns/1ps
interface tick_if;
    logic tick_in;
    logic clear;
    logic [1:0] sel;
    logic tick_out;
    modport ctrl (output tick_in, output clear, output sel, input tick_out);
    modport pre (input tick_in, input clear, input sel, output tick_out);
endinterface

//--- rtl/input_prescaler.sv
/*
 * four-step input prescaler: 1, 8, 64 or 256 ticks per output tick.
 * assumes tick_in is a one-cycle pulse on clk.
 */
`timescale 1ns/1ps
`include "timer_pair_defs.svh"
module input_prescaler (
    input wire logic clk,
    input wire logic sys_rst,
    tick_if.pre t
);
    import timer_pair_pkg::*;

    logic [7:0] count;

    // =====================================================================
    // terminal count per select code
    function automatic logic [7:0] term_count(input prescale_sel_t s);
        case (s)
            2'b11: term_count = `PS_DIV256;
            2'b10: term_count = `PS_DIV64;
            2'b01: term_count = `PS_DIV8;
            default: term_count = `PS_DIV1;
        endcase
    endfunction

    // counter cleared on control writes while running so ratio changes start clean
    always_ff @(posedge clk) begin
        if (sys_rst || t.clear) begin
            count <= 8'h00;
        end else if (t.tick_in) begin
            if (count >= term_count(t.sel)) begin
                count <= 8'h00;
            end else begin
                count <= count + 8'h01;
            end
        end
    end

    assign t.tick_out = t.tick_in && !t.clear && (count >= term_count(t.sel));
endmodule

//--- rtl/timer_pair_control.sv
/*
 * control of the lower timer of a pairable 16-bit timer, APB slave.
 * assumes the counters, period match and interrupt logic sit outside and
 * use count_tick, pair_wide and the upper flag route; device_idle and
 * period_match come from logic on clk, the two pins from outside it.
 */
// Notes on behaviour
// - prescale code 11/10/01/00 divides timer clock by 256/64/8/1
// - source bit set counts external pin rising edges, else half clock
// - bit 13 chooses halting or running while device idles
// - pair bit joins this and next timer into one 32-bit timer
// - gate bit ignored on external clock; with internal it gates accumulation
// - control write while running clears prescaler; software should avoid it
// - bit 15 starts the timer or the pair; clearing stops it
// - in pair mode upper controls ignored, interrupt via upper flag
`timescale 1ns/1ps
`include "timer_pair_defs.svh"
module timer_pair_control (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic device_idle,
    input wire logic ext_clock_pin,
    input wire logic gate_pin,
    input wire logic period_match,
    output logic count_tick,
    output logic gate_end,
    output logic pair_wide,
    output logic timer_running,
    output logic lower_flag_set,
    output logic upper_flag_set
);
    import timer_pair_pkg::*;

    timer_pair_pkg::ctrl_word_t lower_timer_control;
    logic ext_s1, ext_s2, ext_prev;
    logic gate_s1, gate_s2, gate_prev;
    logic half_phase;
    logic wr_ctrl;
    logic setup_phase;
    logic access_phase;
    logic active;
    logic use_gate;
    tick_if t();

    // =====================================================================
    // address decode, shared by the write strobe and the error flag
    function automatic logic hits_ctrl(input logic [11:0] a);
        hits_ctrl = (a == `CTRL_OFFSET);
    endfunction

    function automatic logic hits_map(input logic [11:0] a);
        hits_map = (a == `CTRL_OFFSET) || (a == `STAT_OFFSET);
    endfunction

    // =====================================================================
    // apb access: zero wait states, unmapped addresses answer with error
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    // a write lands only at the access edge, so a refused setup never changes state
    assign wr_ctrl = access_phase && pwrite && hits_ctrl(paddr);

    // control word; unimplemented bits are masked on the way in
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lower_timer_control <= `CTRL_RESET;
        end else if (wr_ctrl) begin
            lower_timer_control <= pwdata[15:0] & `CTRL_WMASK;
        end
    end

    // pready high in the access phase of every transfer, one cycle after setup
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_phase;
        end
    end

    // error rides with pready so the master sees both at the same edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_phase && !hits_map(paddr);
        end
    end

    // read data registered at setup; zero outside a read keeps the bus quiet
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            case (paddr)
                `CTRL_OFFSET: prdata <= {16'h0000, lower_timer_control};
                `STAT_OFFSET: prdata <= {28'h000_0000, use_gate, gate_s2, active, ext_s2};
                default: prdata <= 32'h0000_0000;
            endcase
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    // =====================================================================
    // pin synchronisers; first stage feeds only the second
    // external clock pin: two stages, then one more for the edge detector
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_s1 <= ext_clock_pin;
            ext_s2 <= ext_s1;
            ext_prev <= ext_s2;
        end
    end

    // gate pin: same depth, so both sources see the same latency
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gate_s1 <= 1'b0;
            gate_s2 <= 1'b0;
            gate_prev <= 1'b0;
        end else begin
            gate_s1 <= gate_pin;
            gate_s2 <= gate_s1;
            gate_prev <= gate_s2;
        end
    end

    // instruction clock enable, half of clk
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            half_phase <= 1'b0;
        end else begin
            half_phase <= ~half_phase;
        end
    end

    // =====================================================================
    // run qualification: enable bit, idle halt, gating
    assign active = lower_timer_control[`RUN_BIT]
        && !(device_idle && lower_timer_control[`IDLE_BIT]);
    assign use_gate = lower_timer_control[`GATE_BIT] && !lower_timer_control[`SRC_BIT];

    always_comb begin
        if (lower_timer_control[`SRC_BIT]) begin
            t.tick_in = active && ext_s2 && !ext_prev;
        end else if (use_gate) begin
            t.tick_in = active && half_phase && gate_s2;
        end else begin
            t.tick_in = active && half_phase;
        end
    end
    // any control register write while running restarts the prescale ratio from zero
    assign t.clear = wr_ctrl && lower_timer_control[`RUN_BIT];
    assign t.sel = lower_timer_control[`PS_HI:`PS_LO];

    input_prescaler u_pre (
        .clk(clk),
        .sys_rst(sys_rst),
        .t(t)
    );

    // =====================================================================
    // registered outputs to the counters
    // one tick per prescaled timer clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_tick <= 1'b0;
        end else begin
            count_tick <= t.tick_out;
        end
    end

    // gated mode flags on falling gate edge in addition to period match
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gate_end <= 1'b0;
        end else begin
            gate_end <= active && use_gate && gate_prev && !gate_s2;
        end
    end

    // pair select for the upper timer, which then ignores its own control
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pair_wide <= 1'b0;
        end else begin
            pair_wide <= lower_timer_control[`PAIR_BIT];
        end
    end

    // idle halt drops the running level without touching the control word
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer_running <= 1'b0;
        end else begin
            timer_running <= active;
        end
    end

    // =====================================================================
    // interrupt flag routing
    // single mode keeps the event on this timer's own flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lower_flag_set <= 1'b0;
        end else begin
            lower_flag_set <= period_match && !lower_timer_control[`PAIR_BIT];
        end
    end

    // pair mode routes the event to the upper timer's flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            upper_flag_set <= 1'b0;
        end else begin
            upper_flag_set <= period_match && lower_timer_control[`PAIR_BIT];
        end
    end
endmodule

//--- verification/timer_pair_control_sva.sv
/*
 * port checker for the lower timer control block.
 * assumes it is bound to every timer_pair_control instance on one clock.
 */
`timescale 1ns/1ps
module timer_pair_control_sva (
    input logic clk,
    input logic sys_rst,
    input logic psel,
    input logic penable,
    input logic [11:0] paddr,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic period_match,
    input logic count_tick,
    input logic pair_wide,
    input logic timer_running,
    input logic lower_flag_set,
    input logic upper_flag_set
);
    // =====================================================================
    // properties, one clock, reset disables all
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_err; psel && !penable && paddr != 12'h000 && paddr != 12'h004 |=> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped without error");
    property p_noerr; !pready |-> !pslverr; endproperty
    a_noerr: assert property (p_noerr) else $error("error without ready");
    property p_up; period_match && pair_wide |=> upper_flag_set && !lower_flag_set; endproperty
    a_up: assert property (p_up) else $error("pair flag not on upper");
    property p_lo; period_match && !pair_wide |=> lower_flag_set && !upper_flag_set; endproperty
    a_lo: assert property (p_lo) else $error("single flag not on lower");
    // halted timer must go quiet once the sync pipeline drains
    property p_stop; !timer_running [*8] |-> !count_tick; endproperty
    a_stop: assert property (p_stop) else $error("tick while stopped");
    // fastest source is half clock, so ticks never touch
    property p_gap; count_tick |=> !count_tick; endproperty
    a_gap: assert property (p_gap) else $error("ticks back to back");
    property p_zero; pready && paddr == 12'h000 |-> (prdata & 32'hffff_5f85) == 0; endproperty
    a_zero: assert property (p_zero) else $error("unused bits not zero");
endmodule
bind timer_pair_control timer_pair_control_sva chk_u (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .period_match(period_match), .count_tick(count_tick),
    .pair_wide(pair_wide), .timer_running(timer_running),
    .lower_flag_set(lower_flag_set), .upper_flag_set(upper_flag_set));

//--- verification/timer_pair_control_bench.sv
/*
 * self-checking bench for the lower timer control block.
 * assumes the block answers APB and the checker is bound beside it.
 */
`timescale 1ns/1ps
`define CHK(a, b, m) \
    begin \
        tests_run++; \
        if ((a) !== (b)) begin \
            err_total++; \
            $display("CHECK FAILED %0t %s", $time, m); \
        end \
    end
module timer_pair_control_bench;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, device_idle = 0;
    logic ext_clock_pin = 0, gate_pin = 0, period_match = 0, err_flag;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, count_tick, gate_end, pair_wide, timer_running;
    logic lower_flag_set, upper_flag_set;
    int err_total = 0, tests_run = 0, ticks = 0, ends = 0, c0;
    int ex[4] = '{1024, 128, 16, 4};
    timer_pair_control dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .device_idle(device_idle), .ext_clock_pin(ext_clock_pin),
        .gate_pin(gate_pin), .period_match(period_match), .count_tick(count_tick),
        .gate_end(gate_end), .pair_wide(pair_wide), .timer_running(timer_running),
        .lower_flag_set(lower_flag_set), .upper_flag_set(upper_flag_set));
    // =====================================================================
    // clock, event counters and bus task
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (count_tick === 1'b1) ticks++;
        if (gate_end === 1'b1) ends++;
    end
    // request held until ready is seen at an edge, then released
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // no cycle count assumed; only the watchdog ends a wait that never ends
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err_flag = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task summarize;
        $display("checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // =====================================================================
    // scenarios
    task t_regs;
        apb(0, 12'h000, 0);
        `CHK(rd, 32'h0000_0000, "ctrl reset")
        apb(1, 12'h000, 32'hffff_ffff);
        apb(0, 12'h000, 0);
        `CHK({err_flag, rd}, {1'b0, 32'h0000_a07a}, "ctrl mask")
        apb(1, 12'h000, 0);
        apb(0, 12'h100, 0);
        `CHK({err_flag, rd}, {1'b1, 32'h0000_0000}, "unmapped")
        $display("test regs done");
    endtask
    task t_ps;
        for (int k = 0; k < 4; k++) begin
            apb(1, 12'h000, 32'h0000_8000 | (k << 4));
            c0 = ticks;
            repeat (2048) @(posedge clk);
            c0 = ticks - c0;
            `CHK(c0 >= ex[k] - 1 && c0 <= ex[k] + 1, 1'b1, "prescale rate")
        end
        apb(1, 12'h000, 0);
        repeat (10) @(posedge clk);
        c0 = ticks;
        repeat (100) @(posedge clk);
        `CHK(ticks, c0, "stop")
        $display("test prescale done");
    endtask
    task t_ext;
        apb(1, 12'h000, 32'h0000_8042); // gate set but ignored on pin source
        c0 = ticks;
        repeat (10) begin
            ext_clock_pin <= 1;
            repeat (4) @(posedge clk);
            ext_clock_pin <= 0;
            repeat (4) @(posedge clk);
        end
        repeat (10) @(posedge clk);
        `CHK(ticks - c0, 10, "pin edges")
        `CHK(ticks - c0, 10, "gate ignored")
        $display("test pin done");
    endtask
    task t_gate;
        apb(1, 12'h000, 32'h0000_8040);
        c0 = ticks;
        repeat (200) @(posedge clk);
        `CHK(ticks, c0, "gate closed")
        gate_pin <= 1;
        repeat (200) @(posedge clk);
        `CHK(ticks - c0 >= 98 && ticks - c0 <= 101, 1'b1, "gate open")
        // status: gated mode in use, gate high, running, pin low
        apb(0, 12'h004, 0);
        `CHK({err_flag, rd}, {1'b0, 32'h0000_000e}, "status gated")
        c0 = ends;
        gate_pin <= 0;
        repeat (10) @(posedge clk);
        `CHK(ends - c0, 1, "gate end")
        $display("test gate done");
    endtask
    task t_idle;
        apb(1, 12'h000, 32'h0000_a000);
        device_idle <= 1;
        repeat (10) @(posedge clk);
        c0 = ticks;
        repeat (50) @(posedge clk);
        `CHK({timer_running, ticks == c0}, 2'b01, "idle halt")
        apb(1, 12'h000, 32'h0000_8000);
        repeat (5) @(posedge clk);
        `CHK(timer_running, 1'b1, "idle run")
        device_idle <= 0;
        $display("test idle done");
    endtask
    task t_pair;
        for (int i = 0; i < 2; i++) begin
            apb(1, 12'h000, i ? 32'h0000_0008 : 32'h0000_0000);
            // let pair_wide follow the new word before the event arrives
            repeat (2) @(posedge clk);
            period_match <= 1;
            @(posedge clk);
            period_match <= 0;
            @(posedge clk);
            `CHK({pair_wide, upper_flag_set}, {2{i[0]}}, "pair route")
            `CHK(lower_flag_set, !i[0], "single route")
        end
        $display("test pair done");
    endtask
    task t_rewrite;
        apb(1, 12'h000, 32'h0000_8030);
        c0 = ticks;
        repeat (8) begin
            repeat (100) @(posedge clk);
            apb(1, 12'h000, 32'h0000_8030);
        end
        `CHK(ticks, c0, "rewrite clears prescale")
        apb(1, 12'h000, 0);
        $display("test rewrite done");
    endtask
    // =====================================================================
    // main sequence and watchdog
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 0;
        t_regs;
        t_ps;
        t_ext;
        t_gate;
        t_idle;
        t_pair;
        t_rewrite;
        summarize;
    end
    initial begin
        #2_000_000;
        err_total++;
        summarize;
    end
endmodule
